// ### inc/pcflow_pkg.sv
// Package: constants for program-flow and indirect addressing logic.
// Assumes a single-clock core where each rising clock edge is one instruction cycle.
package pcflow_pkg;

  // Operation codes presented by the instruction decoder
  typedef enum logic [2:0] {
    OP_STEP,     // Plain advance of the counter
    OP_JUMP,     // Unconditional jump, 9-bit target
    OP_CALL,     // Subroutine call, 8-bit target
    OP_PCWRITE,  // Result written into the low counter latch
    OP_RETLIT    // Return with literal
  } pc_op_t;

  localparam int PC_W_DEFAULT   = 11;  // Largest counter width
  localparam int JUMP_BITS      = 9;   // Jump target field width
  localparam int CALL_BITS      = 8;   // Call / low-latch target width
  localparam int PAGE_LO_BIT    = 9;   // First counter bit fed by page bits
  localparam int STATUS_PA_LO   = 5;   // Page bits sit at status 6:5
  localparam int LOC_BITS       = 5;   // Location select inside a bank
  localparam int BANK_LO_BIT    = 5;   // Bank select bits 6:5
  localparam int SHARED_BIT     = 4;   // Location bit 4 low = shared area
  localparam int PTR_W_BANKED   = 7;   // Pointer width when banked
  localparam int PTR_W_FLAT     = 5;   // Pointer width when not banked
  localparam logic [1:0] PAGE_RESET = 2'h0;  // Page bits after reset
  localparam logic [7:0] ADDR_INDIRECT = 8'h00;  // Indirect port address
  localparam logic [7:0] ADDR_POINTER  = 8'h04;  // Pointer register address
  localparam logic [7:0] INDIRECT_SELF_READ = 8'h00;  // Self-read value

endpackage

// ### hw/data_ram.sv
// Data memory: single write port, registered read port.
// Assumes address and write enable are stable around the clock edge.
`timescale 1ns/1ps
`default_nettype none
module data_ram #(
  parameter int AW = 7,  // Address width
  parameter int DW = 8   // Data width
) (
  // Clock
  input  wire logic          clk,
  // Write side
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  // Read side
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);

  // Storage array, contents undefined after reset as in real RAM
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read, one cycle of latency
  always_ff @(posedge clk) begin
    rdData <= mem[rdAddr];
  end

endmodule
`default_nettype wire

// ### hw/pc_stack_indirect.sv
// Program counter, return stack and indirect data addressing of a small
// 8-bit core. The decoder outside presents one operation per clock; each
// rising edge of clk is one instruction cycle.
// Functional notes
// RL1: Page rollover keeps page preselect bits unchanged
// RL2: Branch page always from page preselect bits
// RL3: Reset loads counter with last address
// RL4: Reset clears page preselect bits
// RL5: Two-level return stack, counter width entries
// RL6: Call shifts level one down, pushes pc+1
// RL7: Return pops level one, level two persists
// RL8: Return loads accumulator with instruction literal
// RL9: Indirect port redirects through file select pointer
// RL10: Pointer zero indirect self-read returns zero
// RL11: Indirect write to indirect port stores nothing
// RL12: Pointer is five or seven bits wide
// RL13: Low five pointer bits select location
// RL14: Unbanked upper pointer bits read as ones; filePointer reads bits 6:5 as ones but bit 7 as zero
// RL15: Banked upper pointer bits select bank
// RL16: Counter advances by one unless loaded
// RL17: Jump loads low nine bits directly
// RL18: Call/low-latch write loads 7:0, clears bit 8
// RL19: Status bits six, five feed counter 10:9
// RL20: Low sixteen bank locations alias bank zero
// RL21: Counter width nine, ten or eleven bits
`timescale 1ns/1ps
`default_nettype none
module pc_stack_indirect #(
  parameter int PC_W   = pcflow_pkg::PC_W_DEFAULT,  // 9, 10 or 11
  parameter bit BANKED = 1'b1                       // Banked data memory
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  // Decoded instruction
  input  wire logic            opValid,     // Operation present this cycle
  input  wire logic [2:0]      opCode,      // pc_op_t encoding
  input  wire logic [8:0]      opTarget,    // Jump/call target field
  input  wire logic [7:0]      opLiteral,   // Literal of return instr
  input  wire logic [7:0]      aluResult,   // Value for low-latch writes
  // Status page bits, written by software
  input  wire logic            pageWrEn,
  input  wire logic [1:0]      pageWrData,
  // Data file access from the datapath
  input  wire logic [4:0]      fileAddr,    // Direct file address
  input  wire logic            fileRdEn,
  input  wire logic            fileWrEn,
  input  wire logic [7:0]      fileWrData,
  // Program flow outputs
  output logic      [PC_W-1:0] pc,
  output logic      [1:0]      pagePreselect,
  output logic      [PC_W-1:0] topOfStack,
  output logic      [PC_W-1:0] stackLevel2,
  output logic      [7:0]      accumulator,
  output logic                 accLoad,
  // Data file outputs
  output logic      [7:0]      fileRdData,  // One cycle after fileRdEn
  output logic      [7:0]      filePointer  // Pointer as software reads it
);

  localparam int PW = BANKED ? pcflow_pkg::PTR_W_BANKED
                             : pcflow_pkg::PTR_W_FLAT;  // RL12
  localparam int AW = BANKED ? 7 : 5;  // Data memory address width

  pcflow_pkg::pc_op_t op;  // Decoded operation
  logic [PC_W-1:0] pcPlus;  // Counter plus one
  logic [PC_W-1:0] next_pc;  // Next counter value
  logic [PC_W-1:0] pageBase;  // Page bits placed at counter 10:9
  logic [PW-1:0]   pointer;  // File select pointer register
  logic [6:0]      ptrView;  // Pointer as seen from software
  logic            isIndirect;  // Access through indirect port
  logic [6:0]      effAddr;  // Effective data address
  logic [AW-1:0]   ramAddr;  // Address after shared-area folding
  logic            selfRef;  // Indirect access pointing at the port itself
  logic            ptrSel;  // Access to the pointer register, direct or through the indirect port
  logic            ramWr;  // Store into data memory
  logic [7:0]      ramRd;  // Memory read data
  logic [1:0]      rdSrc;  // Read source for the next cycle
  logic [7:0]      ptrRdHold;  // Pointer value captured for read

  assign op = pcflow_pkg::pc_op_t'(opCode);
  assign pcPlus = pc + {{(PC_W-1){1'b0}}, 1'b1};  // RL16

  // Page bits only reach counter bits that exist; narrower parts drop them
  always_comb begin
    pageBase = '0;
    for (int i = pcflow_pkg::PAGE_LO_BIT; i < PC_W; i++) begin
      pageBase[i] = pagePreselect[i - pcflow_pkg::PAGE_LO_BIT];  // RL19 RL21
    end
  end

  // Counter source selection
  always_comb begin
    next_pc = pcPlus;  // RL16 RL1
    if (opValid) begin
      case (op)
        pcflow_pkg::OP_STEP: begin
          next_pc = pcPlus;  // RL1
        end
        pcflow_pkg::OP_JUMP: begin
          next_pc = pageBase;  // RL2
          next_pc[8:0] = opTarget;  // RL17
        end
        pcflow_pkg::OP_CALL: begin
          next_pc = pageBase;  // RL2
          next_pc[8:0] = {1'b0, opTarget[7:0]};  // RL18
        end
        pcflow_pkg::OP_PCWRITE: begin
          next_pc = pageBase;  // RL2
          next_pc[8:0] = {1'b0, aluResult};  // RL18
        end
        pcflow_pkg::OP_RETLIT: begin
          next_pc = topOfStack;  // RL7
        end
        default: begin
          next_pc = pcPlus;
        end
      endcase
    end
  end

  // Program counter; reset vector is the last word of the last page
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc <= '1;  // RL3
    end else begin
      pc <= next_pc;
    end
  end

  // Page preselect bits; rollover never touches them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pagePreselect <= pcflow_pkg::PAGE_RESET;  // RL4
    end else if (pageWrEn) begin
      pagePreselect <= pageWrData;  // RL1
    end
  end

  // Two-level stack; a third call silently drops the oldest address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      topOfStack  <= '0;
      stackLevel2 <= '0;
    end else if (opValid && op == pcflow_pkg::OP_CALL) begin
      stackLevel2 <= topOfStack;  // RL6 RL5
      topOfStack  <= pcPlus;  // RL6
    end else if (opValid && op == pcflow_pkg::OP_RETLIT) begin
      topOfStack <= stackLevel2;  // RL7 (level two kept)
    end
  end

  // Accumulator load from the literal of a return
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accumulator <= 8'h00;
      accLoad     <= 1'b0;
    end else begin
      accLoad <= opValid && op == pcflow_pkg::OP_RETLIT;
      if (opValid && op == pcflow_pkg::OP_RETLIT) begin
        accumulator <= opLiteral;  // RL8
      end
    end
  end

  // Address resolution for the data file
  always_comb begin
    isIndirect = fileAddr == pcflow_pkg::ADDR_INDIRECT[4:0];  // RL9
    ptrView = '1;  // RL14
    ptrView[PW-1:0] = pointer;  // RL12
    effAddr = isIndirect ? ptrView : {2'h0, fileAddr};  // RL9
    // Bank bits are read from the seven-bit view so that a five-bit
    // pointer build never forms a reversed part-select
    if (isIndirect && BANKED) begin
      effAddr[6:5] = ptrView[6:pcflow_pkg::BANK_LO_BIT];  // RL15
    end else if (!BANKED) begin
      effAddr[6:5] = 2'h0;
    end
    // Lowest sixteen of each bank fold onto bank zero
    if (!effAddr[pcflow_pkg::SHARED_BIT]) begin
      effAddr[6:5] = 2'h0;  // RL20
    end
    ramAddr = effAddr[AW-1:0];  // RL13
    selfRef = isIndirect &&
              effAddr[4:0] == pcflow_pkg::ADDR_INDIRECT[4:0];
    ptrSel  = effAddr[4:0] == pcflow_pkg::ADDR_POINTER[4:0];
    ramWr   = fileWrEn && !selfRef && !ptrSel;  // RL11
  end

  // Pointer register, reachable directly or through itself
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pointer <= '0;
    end else if (fileWrEn && ptrSel && !selfRef) begin
      pointer <= fileWrData[PW-1:0];  // RL12
    end
  end

  // Read source tracking so data line up with the memory latency
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdSrc     <= 2'h0;
      ptrRdHold <= 8'h00;
    end else begin
      ptrRdHold <= {1'b0, ptrView};
      if (!fileRdEn) begin
        rdSrc <= 2'h0;
      end else if (selfRef) begin
        rdSrc <= 2'h1;  // RL10
      end else if (ptrSel) begin
        rdSrc <= 2'h2;
      end else begin
        rdSrc <= 2'h3;
      end
    end
  end

  // Read data mux; idle cycles show zero
  always_comb begin
    case (rdSrc)
      2'h1:    fileRdData = pcflow_pkg::INDIRECT_SELF_READ;  // RL10
      2'h2:    fileRdData = ptrRdHold;
      2'h3:    fileRdData = ramRd;
      default: fileRdData = 8'h00;
    endcase
  end

  assign filePointer = {1'b0, ptrView};  // RL14

  // Data memory behind the indirect port
  data_ram #(
    .AW (AW),
    .DW (8)
  ) uRam (
    .clk    (clk),
    .wrEn   (ramWr),
    .wrAddr (ramAddr),
    .wrData (fileWrData),
    .rdAddr (ramAddr),
    .rdData (ramRd)
  );

endmodule
`default_nettype wire

// ### testbench/pc_stack_indirect_props.sv
// Checker for counter and stack timing at the block ports.
// Assumes the 11-bit counter build; bound onto every instance.
`timescale 1ns/1ps
`default_nettype none
module pc_stack_indirect_props #(
  parameter int PC_W = 11
) (
  // Clock, reset and operation inputs
  input wire logic            clk,
  input wire logic            rst_b,
  input wire logic            opValid,
  input wire logic [2:0]      opCode,
  input wire logic [8:0]      opTarget,
  input wire logic [7:0]      opLiteral,
  // Flow outputs
  input wire logic [PC_W-1:0] pc,
  input wire logic [1:0]      pagePreselect,
  input wire logic [PC_W-1:0] topOfStack,
  input wire logic [PC_W-1:0] stackLevel2,
  input wire logic [7:0]      accumulator,
  input wire logic            accLoad
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic isCall;  // Call taken this cycle
  logic isRet;   // Return taken this cycle
  assign isCall = opValid && opCode == 3'h2;
  assign isRet  = opValid && opCode == 3'h4;
  property p_step; !opValid |=> pc == $past(pc) + 1'b1; endproperty
  a_step: assert property (p_step) else $error("no step");
  property p_page; opValid && opCode inside {3'h1, 3'h2, 3'h3}
    |=> (pc >> 9) == PC_W'($past(pagePreselect)); endproperty
  a_page: assert property (p_page) else $error("bad page");
  property p_jump; opValid && opCode == 3'h1
    |=> pc[8:0] == $past(opTarget); endproperty
  a_jump: assert property (p_jump) else $error("bad jump");
  property p_callLow; isCall |=> pc[8:0] == {1'b0, $past(opTarget[7:0])};
  endproperty
  a_callLow: assert property (p_callLow) else $error("bad call");
  property p_push; isCall |=> topOfStack == $past(pc) + 1'b1
    && stackLevel2 == $past(topOfStack); endproperty
  a_push: assert property (p_push) else $error("bad push");
  property p_pop; isRet |=> pc == $past(topOfStack)
    && topOfStack == $past(stackLevel2) && $stable(stackLevel2); endproperty
  a_pop: assert property (p_pop) else $error("bad pop");
  property p_acc; isRet |=> accLoad && accumulator == $past(opLiteral);
  endproperty
  a_acc: assert property (p_acc) else $error("bad literal");
  property p_noAcc; !isRet |=> !accLoad && $stable(accumulator); endproperty
  a_noAcc: assert property (p_noAcc) else $error("stray load");
endmodule
bind pc_stack_indirect pc_stack_indirect_props #(.PC_W(PC_W)) u_props (
  .clk, .rst_b, .opValid, .opCode, .opTarget, .opLiteral, .pc,
  .pagePreselect, .topOfStack, .stackLevel2, .accumulator, .accLoad);
`default_nettype wire

// ### testbench/test_pc_stack_indirect.sv
// Testbench: cycle model of counter, stack and data file beside the block.
// Assumes the 11-bit banked build; all checks run on every falling edge outside reset.
`timescale 1ns/1ps
`default_nettype none
module test_pc_stack_indirect;
  logic clk, rst_b, opValid, pageWrEn, fileRdEn, fileWrEn, accLoad;
  logic [2:0] opCode;
  logic [8:0] opTarget;
  logic [7:0] opLiteral, aluResult, fileWrData, accumulator;
  logic [7:0] fileRdData, filePointer;
  logic [1:0] pageWrData, pagePreselect, ePage;
  logic [4:0] fileAddr;
  logic [10:0] pc, topOfStack, stackLevel2, ePc, eTop, eL2;
  logic [7:0] eAcc, eRd, mem [128];  // Model of data memory
  logic [6:0] ePtr;
  logic eLd;
  logic [31:0] seed = 32'h7eadc1cc;
  int n_errors = 0, checks = 0;
  pc_stack_indirect #(.PC_W(11), .BANKED(1'b1)) i_pc_stack_indirect (
    .clk, .rst_b, .opValid, .opCode, .opTarget, .opLiteral, .aluResult,
    .pageWrEn, .pageWrData, .fileAddr, .fileRdEn, .fileWrEn, .fileWrData,
    .pc, .pagePreselect, .topOfStack, .stackLevel2, .accumulator, .accLoad,
    .fileRdData, .filePointer);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Shared low half of any bank folds onto bank zero
  function automatic logic [6:0] ea(input logic [4:0] a, input logic [6:0] p);
    logic [4:0] l;
    l = (a == 5'h0) ? p[4:0] : a;
    return l[4] ? {p[6:5], l} : {2'h0, l};
  endfunction
  // Expected state, stepped on the same edges as the block
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ePc <= '1;
      ePage <= 2'h0;
      {eTop, eL2, eAcc, eLd, eRd, ePtr} <= '0;
    end else begin
      ePc <= ePc + 11'h1;
      eLd <= 1'b0;
      eRd <= 8'h00;
      if (pageWrEn) ePage <= pageWrData;
      if (opValid) begin
        case (opCode)
          3'h1: ePc <= {ePage, opTarget};
          3'h2: begin
            ePc <= {ePage, 1'b0, opTarget[7:0]};
            eTop <= ePc + 11'h1;
            eL2 <= eTop;
          end
          3'h3: ePc <= {ePage, 1'b0, aluResult};
          3'h4: begin
            ePc <= eTop;
            eTop <= eL2;
            eAcc <= opLiteral;
            eLd <= 1'b1;
          end
          default: ;
        endcase
      end
      if (fileRdEn) eRd <= (fileAddr == 5'h0 && ePtr[4:0] == 5'h0) ? 8'h00
                           : mem[ea(fileAddr, ePtr)];
      if (fileWrEn && ea(fileAddr, ePtr) == 7'h04) ePtr <= fileWrData[6:0];
      else if (fileWrEn && ea(fileAddr, ePtr) != 7'h00)
        mem[ea(fileAddr, ePtr)] <= fileWrData;
    end
  end
  task automatic chk(input logic [10:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  always @(negedge clk) begin
    if (rst_b === 1'b1) begin
      chk(pc, ePc, "pc");
      chk(11'(pagePreselect), 11'(ePage), "page");
      chk(topOfStack, eTop, "top");
      chk(stackLevel2, eL2, "level2");
      chk(11'(accumulator), 11'(eAcc), "acc");
      chk(11'(accLoad), 11'(eLd), "accLoad");
      chk(11'(fileRdData), 11'(eRd), "rdData");
      chk(11'(filePointer), {4'h0, ePtr}, "pointer");
    end
  end
  // One cycle of inputs; literal and low-latch value are random
  task automatic drv(input logic v, input logic [2:0] c, input logic [8:0] t,
      input logic pw, input logic [1:0] pd, input logic [4:0] a,
      input logic re, we, input logic [7:0] wd);
    @(posedge clk);
    seed = xs(seed);
    opValid <= v;
    opCode <= c;
    opTarget <= t;
    opLiteral <= seed[7:0];
    aluResult <= seed[15:8];
    pageWrEn <= pw;
    pageWrData <= pd;
    fileAddr <= a;
    fileRdEn <= re;
    fileWrEn <= we;
    fileWrData <= wd;
  endtask
  task automatic op(input logic [2:0] c, input logic [8:0] t);
    drv(1'b1, c, t, 1'b0, 2'h0, 5'h0, 1'b0, 1'b0, 8'h00);
  endtask
  task automatic fa(input logic [4:0] a, input logic re, we,
      input logic [7:0] wd);
    drv(1'b0, 3'h0, 9'h0, 1'b0, 2'h0, a, re, we, wd);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end
  initial begin
    logic [31:0] r;
    {opValid, opCode, opTarget, opLiteral, aluResult, pageWrEn} = '0;
    {pageWrData, fileAddr, fileRdEn, fileWrEn, fileWrData} = '0;
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // Wrap, page rollover, then stacked calls and returns on page 3
    op(3'h0, 9'h0);
    op(3'h1, 9'h1ff);
    op(3'h0, 9'h0);
    op(3'h1, 9'h0ab);
    drv(1'b0, 3'h0, 9'h0, 1'b1, 2'h3, 5'h0, 1'b0, 1'b0, 8'h00);
    op(3'h1, 9'h155);
    op(3'h2, 9'h1c3);
    op(3'h2, 9'h022);
    op(3'h2, 9'h033);
    repeat (3) op(3'h4, 9'h0);
    op(3'h3, 9'h0);
    // Fill locations 8 to 31 of every bank through the pointer
    for (int i = 0; i < 128; i++) begin
      if (i[4:3] != 2'h0) begin
        fa(5'h04, 1'b0, 1'b1, 8'(i));
        fa(5'h00, 1'b0, 1'b1, seed[23:16]);
      end
    end
    fa(5'h04, 1'b0, 1'b1, 8'h00);
    fa(5'h00, 1'b1, 1'b1, 8'hff);
    fa(5'h04, 1'b0, 1'b1, 8'h68);
    fa(5'h00, 1'b0, 1'b1, 8'h3c);
    fa(5'h08, 1'b1, 1'b0, 8'h00);
    repeat (300) begin
      seed = xs(seed);
      r = seed;
      case (r[1:0])
        2'h0: drv(1'b1, r[4:2], r[13:5], 1'b0, 2'h0, 5'h0, 1'b0, 1'b0, 8'h00);
        2'h1: fa(5'h04, 1'b0, 1'b1, {1'b0, r[6:4], r[3] | ~r[4], r[2:0]});
        2'h2: fa(5'h00, r[2], 1'b1, r[15:8]);
        default: drv(1'b0, 3'h0, 9'h0, r[2], r[4:3], 5'h0, 1'b1, 1'b0, 8'h00);
      endcase
    end
    // Second reset in mid-run, then a call and a return
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    op(3'h2, 9'h010);
    op(3'h4, 9'h0);
    fa(5'h00, 1'b0, 1'b0, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
